// ---- include/dout_pkg.sv ----
// package: constants and types of the output timing engine
// assumes a 100 MHz system clock and a 32-bit apb register bus
package dout_pkg;
    localparam int DW    = 32;
    localparam int DEPTH = 256;
    localparam int AW    = 8;
    localparam int SW    = 10;
    localparam int CW    = 24;

    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_MODE   = 12'h004;
    localparam logic [11:0] OFS_TRIG   = 12'h008;
    localparam logic [11:0] OFS_DIV    = 12'h00c;
    localparam logic [11:0] OFS_DLY    = 12'h010;
    localparam logic [11:0] OFS_CNT    = 12'h014;
    localparam logic [11:0] OFS_DATA   = 12'h018;
    localparam logic [11:0] OFS_STATUS = 12'h01c;
    localparam logic [11:0] OFS_ROUTE  = 12'h020;

    localparam int CB_START = 0;
    localparam int CB_STOP  = 1;
    localparam int CB_SWTRG = 2;
    localparam int CB_CLEAR = 3;
    localparam int SB_RUN   = 0;
    localparam int SB_ARM   = 1;
    localparam int SB_UFL   = 2;
    localparam int SB_FULL  = 3;
    localparam int SB_EMPTY = 4;
    localparam int SB_LOCK  = 5;
    localparam int SB_LVL   = 8;
    localparam int SYN_AN   = 8;
    localparam int SYN_TB   = 9;

    localparam logic [15:0]   DIV_RST   = 16'h0064;
    localparam logic [15:0]   DLY_RST   = 16'h0000;
    localparam logic [CW-1:0] CNT_RST   = 24'h000001;
    localparam logic [7:0]    MODE_RST  = 8'h00;
    localparam logic [13:0]   TRIG_RST  = 14'h0000;
    localparam logic [16:0]   ROUTE_RST = 17'h00000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_DELAY = 2'b10,
        ST_RUN   = 2'b11
    } eng_st_t;
    typedef enum logic [2:0] {
        SRC_NONE   = 3'b000,
        SRC_SOFT   = 3'b001,
        SRC_PFI    = 3'b010,
        SRC_REF    = 3'b011,
        SRC_START  = 3'b100,
        SRC_ANALOG = 3'b101
    } src_t;
    typedef enum logic [1:0] {
        RG_HOST    = 2'b00,
        RG_ONBOARD = 2'b01,
        RG_NONE    = 2'b10
    } regen_t;
    typedef enum logic [1:0] {
        SS_ONBOARD = 2'b00,
        SS_EXT_TB  = 2'b01,
        SS_PFI     = 2'b10
    } ssrc_t;

    typedef struct packed {
        logic [2:0] spfi;
        ssrc_t      ssrc;
        regen_t     regen;
        logic       cont;
    } mode_t;
    typedef struct packed {
        logic       hlev;
        logic [2:0] hpfi;
        src_t       hsrc;
        logic       bfall;
        logic [2:0] bpfi;
        src_t       bsrc;
    } trig_t;
    typedef struct packed {
        logic       inv;
        logic [7:0] rbeg;
        logic [7:0] rstb;
    } route_t;
    typedef struct packed {
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic [SW-1:0] s3;
        logic [SW-1:0] stab;
    } sync_t;
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   lvl;
    } fifo_t;
    typedef struct packed {
        eng_st_t       st;
        mode_t         mode;
        trig_t         trig;
        route_t        route;
        logic [15:0]   div;
        logic [15:0]   dly;
        logic [CW-1:0] cnt;
        logic [CW-1:0] done;
        logic [15:0]   dcnt;
        logic [15:0]   divc;
        logic [AW-1:0] rep;
        logic          ufl;
        logic          lock;
        logic          tbp;
        logic          bprev;
        logic          sprev;
        logic          ready;
        logic          slverr;
        logic [DW-1:0] rdata;
        logic [DW-1:0] dout;
        logic          upd;
        logic          dreq;
        logic [7:0]    pout;
        logic [7:0]    poe_n;
    } eng_t;
endpackage

// ---- src/dout_sync.sv ----
// three-stage synchroniser for pins, analog event and external timebase
// assumes inputs asynchronous to the system clock
`timescale 1ns/1ps
module dout_sync (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [dout_pkg::SW-1:0] din,
    output logic      [dout_pkg::SW-1:0] dout
);
    dout_pkg::sync_t s_reg;
    dout_pkg::sync_t s_next;

    always_comb
    begin
        s_next      = s_reg;
        s_next.s1   = din;
        s_next.s2   = s_reg.s1;
        s_next.s3   = s_reg.s2;
        // change counts once stages two and three agree
        s_next.stab = (~(s_reg.s2 ^ s_reg.s3) & s_reg.s3)
                    | ((s_reg.s2 ^ s_reg.s3) & s_reg.stab);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign dout = s_reg.stab;
endmodule

// ---- src/dout_fifo.sv ----
// onboard sample fifo with offset peek for replay
// assumes the caller never pops and peeks in one mode at once
`timescale 1ns/1ps
module dout_fifo (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     clr,
    input  wire logic                     push,
    input  wire logic [dout_pkg::DW-1:0]  wdata,
    input  wire logic                     pop,
    input  wire logic [dout_pkg::AW-1:0]  peek,
    output logic      [dout_pkg::DW-1:0]  rdata,
    output logic      [dout_pkg::AW:0]    level,
    output logic                          full,
    output logic                          empty
);
    localparam logic [dout_pkg::AW:0] LVL_MAX = (dout_pkg::AW + 1)'(dout_pkg::DEPTH);
    dout_pkg::fifo_t f_reg;
    dout_pkg::fifo_t f_next;
    logic [dout_pkg::DW-1:0] mem [dout_pkg::DEPTH];
    logic push_ok;
    logic pop_ok;

    always_comb
    begin
        f_next  = f_reg;
        push_ok = push && (f_reg.lvl != LVL_MAX);
        pop_ok  = pop && (f_reg.lvl != '0);
        if (push_ok)
            f_next.wp = f_reg.wp + 8'h01;
        if (pop_ok)
            f_next.rp = f_reg.rp + 8'h01;
        if (push_ok && !pop_ok)
            f_next.lvl = f_reg.lvl + 9'h001;
        else if (pop_ok && !push_ok)
            f_next.lvl = f_reg.lvl - 9'h001;
        if (clr)
            f_next = '0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            f_reg <= '0;
        else
            f_reg <= f_next;
    end

    always_ff @(posedge clk)
    begin
        if (push_ok && !clr)
            mem[f_reg.wp] <= wdata;
    end

    assign rdata = mem[dout_pkg::AW'(f_reg.rp + peek)];
    assign level = f_reg.lvl;
    assign full  = (f_reg.lvl == LVL_MAX);
    assign empty = (f_reg.lvl == '0);
endmodule

// ---- src/dout_engine.sv ----
// digital output timing engine: apb registers, triggers, strobe, fifo
// assumes apb master on CLK_SYS; pins arrive asynchronous
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module dout_engine (
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  PFI_IN,
    input  wire logic        ANALOG_EVENT,
    input  wire logic        EXT_TIMEBASE,
    input  wire logic        IN_REF_TRIG,
    input  wire logic        IN_START_TRIG,
    output logic      [31:0] DO_DATA,
    output logic             DO_UPDATE,
    output logic             DMA_REQ,
    output logic      [7:0]  PFI_OUT,
    output logic      [7:0]  PFI_OE_N
);
    dout_pkg::eng_t r_reg;
    dout_pkg::eng_t r_next;
    logic [dout_pkg::SW-1:0] sy;
    logic [31:0]             f_rdata;
    logic [dout_pkg::AW:0]   f_lvl;
    logic                    f_full;
    logic                    f_empty;
    logic                    f_push;
    logic                    f_pop;
    logic                    f_clr;
    logic [dout_pkg::AW-1:0] f_peek;
    logic                    acc;
    logic                    wr;
    logic                    c_start;
    logic                    c_stop;
    logic                    c_swt;
    logic                    beg_l;
    logic                    fire;
    logic                    hold;
    logic                    onb;
    logic                    tbe;
    logic                    sedge;
    logic                    tick;
    logic                    samp;
    logic                    last;
    logic [15:0]             div1;
    logic [31:0]             rd;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == dout_pkg::OFS_CTRL) || (a == dout_pkg::OFS_MODE)
              || (a == dout_pkg::OFS_TRIG) || (a == dout_pkg::OFS_DIV)
              || (a == dout_pkg::OFS_DLY) || (a == dout_pkg::OFS_CNT)
              || (a == dout_pkg::OFS_DATA) || (a == dout_pkg::OFS_STATUS)
              || (a == dout_pkg::OFS_ROUTE);
    endfunction

    function automatic logic pick(input dout_pkg::src_t s, input logic [2:0] p,
                                  input logic [7:0] pf, input logic an,
                                  input logic rf, input logic sa, input logic sw);
        case (s)
            dout_pkg::SRC_SOFT:   pick = sw;
            dout_pkg::SRC_PFI:    pick = pf[p];
            dout_pkg::SRC_REF:    pick = rf;
            dout_pkg::SRC_START:  pick = sa;
            dout_pkg::SRC_ANALOG: pick = an;
            default:              pick = 1'b0;
        endcase
    endfunction

    dout_sync u_sync (
        .clk   (CLK_SYS),
        .rst_n (RESET_N),
        .din   ({EXT_TIMEBASE, ANALOG_EVENT, PFI_IN}),
        .dout  (sy)
    );

    dout_fifo u_fifo (
        .clk   (CLK_SYS),
        .rst_n (RESET_N),
        .clr   (f_clr),
        .push  (f_push),
        .wdata (PWDATA),
        .pop   (f_pop),
        .peek  (f_peek),
        .rdata (f_rdata),
        .level (f_lvl),
        .full  (f_full),
        .empty (f_empty)
    );

    always_comb
    begin
        r_next   = r_reg;
        r_next.upd = 1'b0;
        acc      = PSEL && PENABLE;
        wr       = acc && r_reg.ready && PWRITE;
        c_start  = wr && (PADDR == dout_pkg::OFS_CTRL) && PWDATA[dout_pkg::CB_START];
        c_stop   = wr && (PADDR == dout_pkg::OFS_CTRL) && PWDATA[dout_pkg::CB_STOP];
        c_swt    = wr && (PADDR == dout_pkg::OFS_CTRL) && PWDATA[dout_pkg::CB_SWTRG];
        f_clr    = wr && (PADDR == dout_pkg::OFS_CTRL) && PWDATA[dout_pkg::CB_CLEAR]
                && (r_reg.st == dout_pkg::ST_IDLE);
        f_push   = wr && (PADDR == dout_pkg::OFS_DATA) && !r_reg.lock;
        onb      = (r_reg.mode.ssrc == dout_pkg::SS_ONBOARD);
        div1     = (r_reg.div == 16'h0000) ? 16'h0000 : r_reg.div - 16'h0001;
        f_peek   = (r_reg.mode.regen == dout_pkg::RG_ONBOARD) ? r_reg.rep : '0;
        f_pop    = 1'b0;
        tick     = 1'b0;
        fire     = 1'b0;
        last     = (r_reg.done + 24'h000001) >= r_reg.cnt;

        beg_l    = pick(r_reg.trig.bsrc, r_reg.trig.bpfi, sy[7:0], sy[dout_pkg::SYN_AN],
                        IN_REF_TRIG, IN_START_TRIG, c_swt) ^ r_reg.trig.bfall;
        r_next.bprev = beg_l;
        hold     = (r_reg.trig.hsrc != dout_pkg::SRC_NONE)
                && (pick(r_reg.trig.hsrc, r_reg.trig.hpfi, sy[7:0], sy[dout_pkg::SYN_AN],
                         IN_REF_TRIG, IN_START_TRIG, c_swt) == r_reg.trig.hlev);
        tbe      = sy[dout_pkg::SYN_TB] && !r_reg.tbp;
        r_next.tbp   = sy[dout_pkg::SYN_TB];
        sedge    = sy[r_reg.mode.spfi] && !r_reg.sprev;
        r_next.sprev = sy[r_reg.mode.spfi];

        // apb answer one cycle into the access phase
        rd = '0;
        case (PADDR)
            dout_pkg::OFS_MODE:   rd[7:0] = r_reg.mode;
            dout_pkg::OFS_TRIG:   rd[13:0] = r_reg.trig;
            dout_pkg::OFS_DIV:    rd[15:0] = r_reg.div;
            dout_pkg::OFS_DLY:    rd[15:0] = r_reg.dly;
            dout_pkg::OFS_CNT:    rd[23:0] = r_reg.cnt;
            dout_pkg::OFS_ROUTE:  rd[16:0] = r_reg.route;
            dout_pkg::OFS_STATUS:
            begin
                rd[dout_pkg::SB_RUN]   = (r_reg.st == dout_pkg::ST_RUN);
                rd[dout_pkg::SB_ARM]   = (r_reg.st == dout_pkg::ST_ARMED)
                                      || (r_reg.st == dout_pkg::ST_DELAY);
                rd[dout_pkg::SB_UFL]   = r_reg.ufl;
                rd[dout_pkg::SB_FULL]  = f_full;
                rd[dout_pkg::SB_EMPTY] = f_empty;
                rd[dout_pkg::SB_LOCK]  = r_reg.lock;
                rd[dout_pkg::SB_LVL +: 9] = f_lvl;
            end
            default:              rd = '0;
        endcase
        r_next.ready  = acc && !r_reg.ready;
        r_next.slverr = 1'b0;
        if (acc && !r_reg.ready)
        begin
            r_next.rdata  = PWRITE ? '0 : rd;
            r_next.slverr = !mapped(PADDR)
                || (PWRITE && (PADDR == dout_pkg::OFS_DATA) && (r_reg.lock || f_full))
                || (PWRITE && (r_reg.st != dout_pkg::ST_IDLE)
                    && (PADDR != dout_pkg::OFS_CTRL) && (PADDR != dout_pkg::OFS_DATA)
                    && (PADDR != dout_pkg::OFS_STATUS));
        end

        if (wr && (r_reg.st == dout_pkg::ST_IDLE))
        begin
            case (PADDR)
                dout_pkg::OFS_MODE:  r_next.mode  = dout_pkg::mode_t'(PWDATA[7:0]);
                dout_pkg::OFS_TRIG:  r_next.trig  = dout_pkg::trig_t'(PWDATA[13:0]);
                dout_pkg::OFS_DIV:   r_next.div   = PWDATA[15:0];
                dout_pkg::OFS_DLY:   r_next.dly   = PWDATA[15:0];
                dout_pkg::OFS_CNT:   r_next.cnt   = PWDATA[23:0];
                dout_pkg::OFS_ROUTE: r_next.route = dout_pkg::route_t'(PWDATA[16:0]);
                default:             r_next.route = r_reg.route;
            endcase
        end
        if (wr && (PADDR == dout_pkg::OFS_STATUS) && PWDATA[dout_pkg::SB_UFL])
            r_next.ufl = 1'b0;
        if (f_clr)
            r_next.lock = 1'b0;

        case (r_reg.st)
            dout_pkg::ST_IDLE:
            begin
                if (c_start)
                begin
                    r_next.st   = dout_pkg::ST_ARMED;
                    r_next.done = '0;
                    r_next.rep  = '0;
                    r_next.lock = (r_reg.mode.regen == dout_pkg::RG_ONBOARD);
                end
            end
            dout_pkg::ST_ARMED:
            begin
                fire = (r_reg.trig.bsrc == dout_pkg::SRC_NONE) || (beg_l && !r_reg.bprev);
                if (fire)
                begin
                    r_next.divc = div1;
                    if ((r_reg.mode.ssrc != dout_pkg::SS_PFI) && (r_reg.dly != 16'h0000))
                    begin
                        r_next.st   = dout_pkg::ST_DELAY;
                        r_next.dcnt = r_reg.dly;
                    end
                    else
                        r_next.st = dout_pkg::ST_RUN;
                end
            end
            dout_pkg::ST_DELAY:
            begin
                r_next.dcnt = r_reg.dcnt - 16'h0001;
                if (r_reg.dcnt == 16'h0001)
                    r_next.st = dout_pkg::ST_RUN;
            end
            dout_pkg::ST_RUN:
            begin
                if (r_reg.mode.ssrc == dout_pkg::SS_PFI)
                    tick = sedge;
                else if (!(hold && onb) && (onb || tbe))
                begin
                    if (r_reg.divc >= div1)
                    begin
                        tick = 1'b1;
                        r_next.divc = '0;
                    end
                    else
                        r_next.divc = r_reg.divc + 16'h0001;
                end
            end
            default:
                r_next.st = dout_pkg::ST_IDLE;
        endcase

        // other strobes are dropped while the hold is active
        samp = tick && !hold;
        if (samp)
        begin
            if (r_reg.mode.regen == dout_pkg::RG_ONBOARD)
            begin
                if (f_empty)
                    r_next.ufl = 1'b1;
                else
                begin
                    r_next.dout = f_rdata;
                    r_next.upd  = 1'b1;
                    r_next.rep  = ({1'b0, r_reg.rep} + 9'h001 >= f_lvl) ? '0
                                : r_reg.rep + 8'h01;
                end
            end
            else if (!f_empty)
            begin
                f_pop       = 1'b1;
                r_next.dout = f_rdata;
                r_next.upd  = 1'b1;
            end
            else if (r_reg.mode.regen == dout_pkg::RG_HOST)
                r_next.upd = 1'b1;
            else
                r_next.ufl = 1'b1;
            if (r_next.upd)
                r_next.done = r_reg.done + 24'h000001;
            if ((r_next.upd && !r_reg.mode.cont && last) || !r_next.upd)
                r_next.st = dout_pkg::ST_IDLE;
        end
        if (c_stop)
            r_next.st = dout_pkg::ST_IDLE;

        r_next.dreq = (r_next.st != dout_pkg::ST_IDLE) && !r_next.lock && !f_full;
        r_next.pout  = (r_reg.route.rstb & {8{r_next.upd ^ r_reg.route.inv}})
                     | (r_reg.route.rbeg & {8{fire}});
        r_next.poe_n = ~(r_reg.route.rstb | r_reg.route.rbeg);
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            r_reg       <= '0;
            r_reg.div   <= dout_pkg::DIV_RST;
            r_reg.dly   <= dout_pkg::DLY_RST;
            r_reg.cnt   <= dout_pkg::CNT_RST;
            r_reg.mode  <= dout_pkg::mode_t'(dout_pkg::MODE_RST);
            r_reg.trig  <= dout_pkg::trig_t'(dout_pkg::TRIG_RST);
            r_reg.route <= dout_pkg::route_t'(dout_pkg::ROUTE_RST);
            r_reg.poe_n <= 8'hff;
        end
        else
            r_reg <= r_next;
    end

    assign PRDATA    = r_reg.rdata;
    assign PREADY    = r_reg.ready;
    assign PSLVERR   = r_reg.slverr;
    assign DO_DATA   = r_reg.dout;
    assign DO_UPDATE = r_reg.upd;
    assign DMA_REQ   = r_reg.dreq;
    assign PFI_OUT   = r_reg.pout;
    assign PFI_OE_N  = r_reg.poe_n;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);

    fin_stop_a: assert property ((r_reg.st == dout_pkg::ST_RUN) && samp && !f_empty
        && !r_reg.mode.cont && last && !c_stop |=> r_reg.st == dout_pkg::ST_IDLE)
        else $error("finite run did not stop");
    ufl_flag_a: assert property ((r_reg.mode.regen == dout_pkg::RG_NONE) && samp
        && f_empty |=> r_reg.ufl && !DO_UPDATE)
        else $error("underflow not flagged");
    upd_data_a: assert property (samp && !f_empty
        && (r_reg.mode.regen != dout_pkg::RG_ONBOARD) |=> DO_UPDATE && DO_DATA == $past(f_rdata))
        else $error("update without fifo word");
    hold_blk_a: assert property (hold |=> !DO_UPDATE)
        else $error("sample during hold");
    lock_err_a: assert property (acc && !r_reg.ready && PWRITE && r_reg.lock
        && (PADDR == dout_pkg::OFS_DATA) |=> PREADY && PSLVERR)
        else $error("write to locked fifo accepted");
    sw_start_a: assert property ((r_reg.st == dout_pkg::ST_ARMED)
        && (r_reg.trig.bsrc == dout_pkg::SRC_NONE) |=> r_reg.st != dout_pkg::ST_ARMED)
        else $error("software start stalled");
    dly_hold_a: assert property ((r_reg.st == dout_pkg::ST_DELAY) && (r_reg.dcnt > 16'h0001)
        && !c_stop |=> (r_reg.st == dout_pkg::ST_DELAY) && !DO_UPDATE)
        else $error("delay cut short");
    div_frz_a: assert property ((r_reg.st == dout_pkg::ST_RUN) && hold && onb
        |=> r_reg.divc == $past(r_reg.divc))
        else $error("divider ran in hold");
    tb_edge_a: assert property ((r_reg.st == dout_pkg::ST_RUN) && !tbe && !c_stop
        && (r_reg.mode.ssrc == dout_pkg::SS_EXT_TB) |=> r_reg.divc == $past(r_reg.divc))
        else $error("divider ran without timebase edge");
    beg_pin_a: assert property (fire |=> (PFI_OUT & r_reg.route.rbeg) == r_reg.route.rbeg)
        else $error("begin pulse missing on terminal");
endmodule

// ---- tb/dout_sink.sv ----
// partner: output module that latches each update
// assumes update is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module dout_sink (
    input  wire logic        clk,
    input  wire logic        upd,
    input  wire logic [31:0] data,
    output int               cnt,
    output logic      [31:0] last
);
    int n = 0;
    assign cnt = n;
    always @(posedge clk)
    begin
        if (upd === 1'b1)
        begin
            n <= n + 1;
            last <= data;
        end
    end
endmodule

// ---- tb/test_digital_output_timing_engine.sv ----
// testbench: apb register sequences against the timing engine
// assumes one wait state apb slave and a registered update strobe
`timescale 1ns/1ps
module test_digital_output_timing_engine;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pw = 0;
    logic [11:0] pa = '0;
    logic [31:0] wd = '0, rd, prdata, last, do_data;
    logic        pready, perr, e, do_upd, dma;
    logic [8:0]  pin = '0;
    logic        an = 0;
    logic [7:0]  pfi_out, pfi_oe_n;
    int          n_mismatch = 0, total_checks = 0, cyc = 0, cnt;
    int          c0 = 0, n_beg = 0, n_stb = 0;
    always #5 clk = ~clk;
    dout_engine i_dut (.CLK_SYS(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pw), .PADDR(pa), .PWDATA(wd), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(perr), .PFI_IN(pin[7:0]), .ANALOG_EVENT(an), .EXT_TIMEBASE(pin[8]),
        .IN_REF_TRIG(1'b0), .IN_START_TRIG(1'b0), .DO_DATA(do_data), .DO_UPDATE(do_upd),
        .DMA_REQ(dma), .PFI_OUT(pfi_out), .PFI_OE_N(pfi_oe_n));
    dout_sink i_sink (.clk(clk), .upd(do_upd), .data(do_data), .cnt(cnt), .last(last));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pw <= w; pa <= a; wd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_idle();
        do apb(0, dout_pkg::OFS_STATUS, '0); while (rd[dout_pkg::SB_RUN] !== 1'b0);
    endtask
    task automatic pulse(input int b);
        pin[b] <= 1'b1;
        repeat (4) @(posedge clk);
        pin[b] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (pfi_out[5] === 1'b1)
            n_beg++;
        if (pfi_out[4] === 1'b1)
            n_stb++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        chk({24'h0, pfi_oe_n}, 32'h000000ff);
        chk({31'h0, dma}, 32'h0);
        apb(0, dout_pkg::OFS_DIV, '0);
        chk(rd, 32'h00000064);
        apb(0, 12'h0f0, '0);
        chk({31'h0, e}, 32'h1);
        $display("reset test done");
        // finite host mode, three words, divisor four
        apb(1, dout_pkg::OFS_CNT, 32'h3);
        apb(1, dout_pkg::OFS_DIV, 32'h4);
        for (int i = 1; i <= 3; i++)
            apb(1, dout_pkg::OFS_DATA, 32'ha5a50000 + i);
        apb(1, dout_pkg::OFS_CTRL, 32'h1);
        wait_idle();
        chk(cnt, 3);
        chk(last, 32'ha5a50003);
        chk(rd, 32'h00000010);
        $display("finite test done");
        // continuous non-regeneration with an empty fifo
        apb(1, dout_pkg::OFS_MODE, 32'h5);
        apb(1, dout_pkg::OFS_CTRL, 32'h1);
        wait_idle();
        chk(rd, 32'h00000014);
        chk(cnt, 3);
        apb(1, dout_pkg::OFS_STATUS, 32'h4);
        apb(0, dout_pkg::OFS_STATUS, '0);
        chk(rd, 32'h00000010);
        $display("underflow test done");
        // continuous onboard replay of two words
        apb(1, dout_pkg::OFS_MODE, 32'h3);
        apb(1, dout_pkg::OFS_DATA, 32'h11);
        apb(1, dout_pkg::OFS_DATA, 32'h22);
        apb(1, dout_pkg::OFS_CTRL, 32'h1);
        apb(1, dout_pkg::OFS_DATA, 32'h33);
        chk({31'h0, e}, 32'h1);
        apb(1, dout_pkg::OFS_DIV, 32'h9);
        chk({31'h0, e}, 32'h1);
        repeat (40) @(posedge clk);
        apb(0, dout_pkg::OFS_STATUS, '0);
        chk(rd, 32'h00000221);
        chk({31'h0, cnt > 6}, 32'h1);
        apb(1, dout_pkg::OFS_CTRL, 32'h2);
        wait_idle();
        chk(rd, 32'h00000220);
        apb(0, dout_pkg::OFS_DIV, '0);
        chk(rd, 32'h00000004);
        $display("onboard test done");
        // terminal begin, delay, external timebase held then released
        apb(1, dout_pkg::OFS_CTRL, 32'h8);
        apb(1, dout_pkg::OFS_MODE, 32'h8);
        apb(1, dout_pkg::OFS_TRIG, 32'h290a);
        apb(1, dout_pkg::OFS_DLY, 32'h5);
        apb(1, dout_pkg::OFS_DIV, 32'h2);
        apb(1, dout_pkg::OFS_CNT, 32'h2);
        apb(1, dout_pkg::OFS_ROUTE, 32'h2010);
        apb(1, dout_pkg::OFS_DATA, 32'h5a);
        apb(1, dout_pkg::OFS_DATA, 32'h5b);
        apb(1, dout_pkg::OFS_CTRL, 32'h1);
        apb(0, dout_pkg::OFS_STATUS, '0);
        chk(rd, 32'h00000202);
        chk({31'h0, dma}, 32'h1);
        chk({24'h0, pfi_oe_n}, 32'h000000cf);
        c0 = cnt;
        pin[2:1] <= 2'b11;
        repeat (14) @(posedge clk);
        chk(n_beg, 1);
        repeat (3) pulse(8);
        chk(cnt, c0);
        pin[2] <= 1'b0;
        repeat (6) @(posedge clk);
        repeat (4) pulse(8);
        wait_idle();
        chk(cnt, c0 + 2);
        chk(last, 32'h0000005b);
        chk(n_stb, 2);
        chk(rd, 32'h00000010);
        $display("terminal trigger test done");
        // software begin, analog hold, terminal strobe, host repeat
        c0 = cnt;
        an <= 1'b1;
        apb(1, dout_pkg::OFS_MODE, 32'h71);
        apb(1, dout_pkg::OFS_TRIG, 32'h2281);
        apb(1, dout_pkg::OFS_CTRL, 32'h1);
        apb(1, dout_pkg::OFS_CTRL, 32'h4);
        repeat (2) pulse(3);
        chk(cnt, c0);
        an <= 1'b0;
        repeat (6) @(posedge clk);
        repeat (3) pulse(3);
        chk(cnt, c0 + 3);
        chk(n_beg, 2);
        apb(1, dout_pkg::OFS_CTRL, 32'h2);
        wait_idle();
        chk(rd, 32'h00000010);
        $display("software trigger test done");
        conclude();
    end
endmodule
